// ==== rtl/fram_pkg.sv ====
package fram_pkg;

    // ------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------
    localparam int          MEM_DEPTH     = 8192;
    localparam int          ADDR_W        = 13;
    localparam int          DATA_W        = 8;
    localparam logic [12:0] ADDR_LAST     = 13'h1fff;
    localparam logic [12:0] ADDR_RESET    = 13'h0000;

    // ------------------------------------------------------------
    // slave address byte layout
    // ------------------------------------------------------------
    localparam int          TYPE_MSB      = 7;
    localparam int          TYPE_LSB      = 4;
    localparam int          SEL_MSB       = 3;
    localparam int          SEL_LSB       = 1;
    localparam int          DIR_BIT       = 0;
    localparam logic        DIR_WRITE     = 1'b0;
    localparam logic        DIR_READ      = 1'b1;
    localparam logic [3:0]  BIT_LAST      = 4'h7;
    localparam logic [3:0]  BIT_ACK       = 4'h8;

    // ------------------------------------------------------------
    // link timing
    // ------------------------------------------------------------
    localparam int          CLK_NS        = 100;
    localparam int          FIFO_DEPTH    = 4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [12:0] addr;
        logic [7:0]  data;
    } wr_req_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WRDATA,
        ST_RDDATA,
        ST_IGNORE
    } link_state_t;

endpackage

// ==== rtl/fram_i2c_slave_interface.sv ====
// Behaviour
// - holds 8,192 bytes, read and written over the serial link
// - responds only when received select bits equal the strap levels
// - unconnected select strap reads as low
// - write-inhibit high blocks every write; reads always work
// - unconnected write-inhibit reads as low, memory writable
// - acts only as slave, never drives the serial clock
// - data changes only while clock low, except start and stop
// - data falling while clock high marks a start
// - data rising while clock high marks a stop
// - on stop return to standby at once, ready immediately
// - bytes of 8 bits, receiver pulls data low on 9th clock
// - sender releases the data line during the acknowledge clock
// - stop before acknowledge ends the read, device to standby
// - no acknowledge and no stop: stay idle with data released
// - first byte: type code, three select bits descending, direction bit
// - direction 0 selects write, 1 selects read
// - two memory address bytes, high first, each acknowledged
// - address increments after each data byte, wraps to zero
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// write fifo between link and memory array
// ----------------------------------------------------------------
module fram_wr_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wp_r;
    logic [PW-1:0]    rp_r;
    logic [PW:0]      cnt_r;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rp_r];

    // pointer and occupancy bookkeeping
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            if (pop)  rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // storage, no reset needed
    always_ff @(posedge clock_i) begin
        if (push) mem_r[wp_r] <= in_data_i;
    end
endmodule

// ----------------------------------------------------------------
// serial slave with memory array
// ----------------------------------------------------------------
module fram_i2c_slave_interface
    import fram_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = 4'h5  // arbitrary neutral device type code
) (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    // serial bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // straps
    input  wire logic [2:0] device_select_straps_i,
    input  wire logic       write_inhibit_i,
    // status
    output logic            busy_o
);
    // ------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------
    logic       rst_s1_r;
    logic       rst_n;
    bus_pins_t  pin_s1_r;
    bus_pins_t  pin_s2_r;
    bus_pins_t  pin_d_r;
    logic [3:0] strap_s1_r;
    logic [3:0] strap_s2_r;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // bus idles high, so reset values match a released bus
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r   <= '{scl: 1'b1, sda: 1'b1};
            pin_s2_r   <= '{scl: 1'b1, sda: 1'b1};
            pin_d_r    <= '{scl: 1'b1, sda: 1'b1};
            strap_s1_r <= 4'h0;
            strap_s2_r <= 4'h0;
        end else begin
            pin_s1_r   <= '{scl: scl_i, sda: sda_i};
            pin_s2_r   <= pin_s1_r;
            pin_d_r    <= pin_s2_r;
            // floating straps are pulled down externally, seen low
            strap_s1_r <= {write_inhibit_i, device_select_straps_i};
            strap_s2_r <= strap_s1_r;
        end
    end

    // ------------------------------------------------------------
    // bus event decode
    // ------------------------------------------------------------
    wire scl_rise  = pin_s2_r.scl && !pin_d_r.scl;
    wire scl_fall  = !pin_s2_r.scl && pin_d_r.scl;
    wire scl_high  = pin_s2_r.scl && pin_d_r.scl;
    wire start_det = scl_high && pin_d_r.sda && !pin_s2_r.sda;
    wire stop_det  = scl_high && !pin_d_r.sda && pin_s2_r.sda;
    wire wp_on     = strap_s2_r[3];

    // ------------------------------------------------------------
    // link state
    // ------------------------------------------------------------
    link_state_t  st_r;
    logic [3:0]   bit_r;
    logic [7:0]   sh_r;
    logic [12:0]  addr_r;
    logic         ack_phase_r;   // currently in 9th clock
    logic         rx_ack_r;      // this ack slot follows a byte we took in
    logic         drive_low_r;
    link_state_t  st_nxt;
    logic [3:0]   bit_nxt;
    logic [7:0]   sh_nxt;
    logic [12:0]  addr_nxt;
    logic         ack_phase_nxt;
    logic         rx_ack_nxt;
    logic [7:0]   mem_r [MEM_DEPTH];
    logic [7:0]   rd_byte_r;

    wire [7:0]  byte_in   = {sh_r[6:0], pin_s2_r.sda};
    wire        last_bit  = (bit_r == BIT_LAST);
    wire        dev_match = (byte_in[TYPE_MSB:TYPE_LSB] == TYPE_CODE) &&
                            (byte_in[SEL_MSB:SEL_LSB] == strap_s2_r[2:0]);
    wire        rx_state  = (st_r == ST_DEVADDR) || (st_r == ST_ADDR_HI) ||
                            (st_r == ST_ADDR_LO) || (st_r == ST_WRDATA);

    // address step with wrap to zero
    function automatic logic [12:0] next_addr(input logic [12:0] a);
        next_addr = (a == ADDR_LAST) ? ADDR_RESET : a + 13'h0001;
    endfunction

    // write path goes through the fifo; stall blocks the ack
    wr_req_t wr_req;
    wr_req_t wr_out;
    logic    wr_push;
    logic    wr_ready;
    logic    wr_valid;
    wire     wr_take = 1'b1;

    assign wr_req  = '{addr: addr_r, data: byte_in};
    assign wr_push = (st_r == ST_WRDATA) && scl_rise && last_bit && !ack_phase_r && !wp_on;

    fram_wr_fifo #(
        .WIDTH ($bits(wr_req_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (wr_push),
        .in_ready_o  (wr_ready),
        .in_data_i   (wr_req),
        .out_valid_o (wr_valid),
        .out_ready_i (wr_take),
        .out_data_o  (wr_out)
    );

    // array write and read port
    always_ff @(posedge clock_i) begin
        if (wr_valid) mem_r[wr_out.addr] <= wr_out.data;
        rd_byte_r <= mem_r[addr_r];
    end

    // ------------------------------------------------------------
    // receive/transmit sequencing on sampled clock edges
    // ------------------------------------------------------------
    // priority: stop, then start, then a data bit, then the ack bit
    always_comb begin
        st_nxt        = st_r;
        bit_nxt       = bit_r;
        sh_nxt        = sh_r;
        addr_nxt      = addr_r;
        ack_phase_nxt = ack_phase_r;
        rx_ack_nxt    = rx_ack_r;
        if (stop_det) begin
            st_nxt        = ST_IDLE;
            ack_phase_nxt = 1'b0;
        end else if (start_det) begin
            st_nxt        = ST_DEVADDR;
            bit_nxt       = 4'h0;
            ack_phase_nxt = 1'b0;
        end else if (scl_rise && !ack_phase_r) begin
            sh_nxt  = byte_in;
            bit_nxt = last_bit ? 4'h0 : bit_r + 4'h1;
            if (last_bit) begin
                ack_phase_nxt = (st_r != ST_IDLE) && (st_r != ST_IGNORE);
                // the read address byte is ours to ack although st turns to read
                rx_ack_nxt    = rx_state;
                case (st_r)
                    ST_DEVADDR: begin
                        if (!dev_match) begin
                            st_nxt = ST_IGNORE;
                        end else if (byte_in[DIR_BIT] == DIR_READ) begin
                            st_nxt = ST_RDDATA;
                        end else begin
                            st_nxt = ST_ADDR_HI;
                        end
                    end
                    ST_ADDR_HI: begin
                        addr_nxt[12:8] = byte_in[4:0];
                        st_nxt         = ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        addr_nxt[7:0] = byte_in;
                        st_nxt        = ST_WRDATA;
                    end
                    ST_WRDATA: begin
                        addr_nxt = next_addr(addr_r);
                    end
                    ST_RDDATA: begin
                        addr_nxt = next_addr(addr_r);
                    end
                    default: begin
                        st_nxt = st_r;
                    end
                endcase
            end
        end else if (scl_rise && ack_phase_r) begin
            ack_phase_nxt = 1'b0;
            // only the master's own ack slot may end a read
            if (st_r == ST_RDDATA && !rx_ack_r && pin_s2_r.sda) begin
                st_nxt = ST_IGNORE;
            end
        end
    end

    // link state registers
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r        <= ST_IDLE;
            bit_r       <= 4'h0;
            sh_r        <= 8'h00;
            addr_r      <= ADDR_RESET;
            ack_phase_r <= 1'b0;
            rx_ack_r    <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            bit_r       <= bit_nxt;
            sh_r        <= sh_nxt;
            addr_r      <= addr_nxt;
            ack_phase_r <= ack_phase_nxt;
            rx_ack_r    <= rx_ack_nxt;
        end
    end

    // ------------------------------------------------------------
    // open-drain output, loaded on clock fall, released at once on start, stop or idle
    // ------------------------------------------------------------
    wire rd_bit    = rd_byte_r[3'(BIT_LAST[2:0] - bit_r[2:0])];
    wire ack_ok    = rx_ack_r && (st_r != ST_WRDATA || wr_ready);  // fifo full withholds ack
    wire want_low  = ack_phase_r ? ack_ok :
                     (st_r == ST_RDDATA) ? !rd_bit : 1'b0;

    // direction read handled after the ack of the address byte
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            drive_low_r <= 1'b0;
        end else if (stop_det || start_det || st_r == ST_IDLE || st_r == ST_IGNORE) begin
            drive_low_r <= 1'b0;
        end else if (scl_fall) begin
            drive_low_r <= want_low;
        end
    end

    // status flag for observers
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) busy_o <= 1'b0;
        else        busy_o <= (st_r != ST_IDLE) && (st_r != ST_IGNORE);
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = drive_low_r;
endmodule

`default_nettype wire

// ==== testbench/fram_i2c_slave_interface_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// pin-level protocol checks
// ----
module fram_i2c_slave_interface_sva #(
    parameter logic [3:0] TYPE_CODE = 4'h5
) (
    // watched ports
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [2:0] device_select_straps_i,
    input wire logic       write_inhibit_i,
    input wire logic       busy_o
);
    logic       scl_q, sda_q, first_r, act_r, dir_r;
    logic [3:0] cnt_r;
    logic [8:0] sh_r;
    // bus events; the ninth bit shifts in too, so the byte sits in 8:1
    wire start_w = scl_q & scl_i & sda_q & ~sda_i;
    wire stop_w  = scl_q & scl_i & ~sda_q & sda_i;
    wire rise_w  = ~scl_q & scl_i;
    wire fall9_w = scl_q & ~scl_i & (cnt_r == 4'h9);
    wire match_w = (sh_r[8:5] == TYPE_CODE) & (sh_r[4:2] == device_select_straps_i);
    // bit count and byte role, restarted by every start
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {scl_q, sda_q, first_r, act_r, dir_r} <= 5'h18;
            cnt_r <= 4'h0;
            sh_r  <= 9'h000;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            if (start_w) begin
                {cnt_r, first_r, act_r} <= 6'h02;
            end else if (stop_w) begin
                {cnt_r, act_r} <= 5'h00;
            end else if (rise_w) begin
                cnt_r <= cnt_r + 4'h1;
                sh_r  <= {sh_r[7:0], sda_i};
            end else if (fall9_w) begin
                cnt_r   <= 4'h0;
                first_r <= 1'b0;
                act_r   <= first_r ? match_w : act_r & ~(dir_r & sda_i);
                dir_r   <= first_r ? sh_r[1] : dir_r;
            end
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    sequence s_stop;
        stop_w;
    endsequence
    sequence s_idle_back;
        ##[1:8] (!busy_o && !sda_oe_o);
    endsequence
    a_no_high: assert property (!sda_o) else $error("drove high");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i)) else $error("moved in high");
    a_addr_ack: assert property (fall9_w && first_r && match_w |-> sda_oe_o) else $error("no addr ack");
    a_addr_nack: assert property (fall9_w && first_r && !match_w |-> !sda_oe_o) else $error("bad ack");
    a_write_ack: assert property (fall9_w && !first_r && act_r && !dir_r |-> sda_oe_o) else $error("no ack");
    a_busy_on: assert property (fall9_w && first_r && match_w |-> busy_o) else $error("not busy");
    a_read_free: assert property (fall9_w && !first_r && act_r && dir_r |-> !sda_oe_o) else $error("held");
    a_rx_quiet: assert property ((first_r || act_r && !dir_r) && scl_q && cnt_r < 4'h9 |-> !sda_oe_o)
        else $error("drove while rx");
    a_idle_quiet: assert property (!first_r && !act_r |-> !sda_oe_o) else $error("drove idle");
    a_stop_idle: assert property (s_stop |-> s_idle_back) else $error("no standby");
    a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |-> !sda_oe_o && !busy_o)
        else $error("active in reset");
endmodule
bind fram_i2c_slave_interface fram_i2c_slave_interface_sva #(.TYPE_CODE(TYPE_CODE)) u_sva (.clock_i(clock_i),
    .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .device_select_straps_i(device_select_straps_i), .write_inhibit_i(write_inhibit_i), .busy_o(busy_o));
`default_nettype wire

// ==== testbench/i2c_master.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// bus master, sole owner of the serial clock
// ----
module i2c_master (
    // clock
    input  wire logic clock_i,
    // bus; a 1 on sda_o releases the line
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_o
);
    // lines released and clock parked high between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // 500 ns low, 300 ns high; read late in high, device answers slowly
    task automatic slot(input logic b, output logic r);
        tick(2);
        sda_o <= b;
        tick(3);
        scl_o <= 1'b1;
        tick(3);
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    task automatic start();
        tick(2);
        sda_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(3);
        sda_o <= 1'b0;
        tick(3);
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_o <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(3);
        sda_o <= 1'b1;
        tick(4);
    endtask
    // msb first, then let go for the answer
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) slot(b[i], r);
        slot(1'b1, ack);
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) slot(1'b1, b[i]);
        slot(last, r);
    endtask
endmodule
`default_nettype wire

// ==== testbench/fram_i2c_slave_interface_test.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// random write and read-back over the serial link
// ----
module fram_i2c_slave_interface_test;
    localparam logic [3:0] TYPE_CODE = 4'h5; // arbitrary type code
    logic        clock_i, resetn_i, wp, scl, m_sda, sda_o, sda_oe_o, busy_o;
    logic [2:0]  sel;
    logic [7:0]  d, exp_mem [0:8191];
    logic [12:0] base;
    logic [15:0] rnd;
    int          err_total, checked;
    // open-drain wire with pull-up
    wire         sda_w = m_sda & ~(sda_oe_o & ~sda_o);
    fram_i2c_slave_interface #(.TYPE_CODE(TYPE_CODE)) u_fram_i2c_slave_interface (.clock_i(clock_i),
        .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .device_select_straps_i(sel), .write_inhibit_i(wp), .busy_o(busy_o));
    i2c_master u_i2c_master (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
    always #50 clock_i = ~clock_i;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // memory address of the k-th byte of a run, wrapping at the top
    function automatic logic [12:0] run_addr(input logic [12:0] a, input int k);
        return a + 13'(k);
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // select, then the two address bytes, high first
    task automatic addr_phase(input logic [12:0] a);
        logic [2:0] ack;
        u_i2c_master.start();
        u_i2c_master.wr_byte({TYPE_CODE, sel, 1'b0}, ack[2]);
        u_i2c_master.wr_byte({3'h0, a[12:8]}, ack[1]);
        u_i2c_master.wr_byte(a[7:0], ack[0]);
        cmp({5'h00, ack}, 8'h00);
    endtask
    task automatic write_run(input logic [12:0] a, input int n, input logic inhibit);
        logic ack;
        wp <= inhibit;
        addr_phase(a);
        for (int k = 0; k < n; k++) begin
            rnd = lfsr(rnd);
            u_i2c_master.wr_byte(rnd[7:0], ack);
            cmp({7'h00, ack}, 8'h00);
            if (!inhibit) exp_mem[run_addr(a, k)] = rnd[7:0];
        end
        u_i2c_master.stop();
    endtask
    task automatic read_run(input logic [12:0] a, input int n);
        logic ack;
        addr_phase(a);
        u_i2c_master.start();
        u_i2c_master.wr_byte({TYPE_CODE, sel, 1'b1}, ack);
        cmp({7'h00, ack}, 8'h00);
        for (int k = 0; k < n; k++) begin
            u_i2c_master.rd_byte(k == n - 1, d);
            cmp(d, exp_mem[run_addr(a, k)]);
        end
        u_i2c_master.stop();
    endtask
    // main sequence: wrap, refusals, inhibit, restart mid-byte
    initial begin
        clock_i = 1'b0;
        resetn_i = 1'b0;
        wp = 1'b0;
        sel = 3'h0;
        rnd = 16'h0a9b;
        err_total = 0;
        checked = 0;
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        cmp({6'h00, sda_oe_o, busy_o}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            sel <= rnd[2:0];
            base = (i == 0) ? 13'h1ffe : rnd[15:3];
            @(posedge clock_i);
            write_run(base, 3, 1'b0);
            read_run(base, 3);
        end
        for (int j = 0; j < 2; j++) begin
            u_i2c_master.start();
            u_i2c_master.wr_byte(j == 0 ? {TYPE_CODE, ~sel, 1'b1} : {TYPE_CODE ^ 4'h3, sel, 1'b1}, d[0]);
            cmp({7'h00, d[0]}, 8'h01);
            u_i2c_master.rd_byte(1'b1, d);
            cmp(d, 8'hff);
            u_i2c_master.stop();
        end
        write_run(base, 1, 1'b1);
        read_run(base, 1);
        u_i2c_master.start();
        repeat (3) u_i2c_master.slot(1'b0, d[0]);
        write_run(13'h0100, 2, 1'b0);
        read_run(13'h0100, 2);
        end_sim();
    end
    // hang guard; the run needs about 5900 cycles
    initial begin
        repeat (40000) @(posedge clock_i);
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
